// File: brtc_ctl.sv
// Bridge tuning control registers with APB slave and the timers they steer
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module brtc_ctl #(
    parameter int CRS1_CYC = brtc_pkg::CRS1_CYC,
    parameter int CRS2_CYC = brtc_pkg::CRS2_CYC,
    parameter int CRS3_CYC = brtc_pkg::CRS3_CYC,
    parameter int CPL1_CYC = brtc_pkg::CPL1_CYC,
    parameter int CPL2_CYC = brtc_pkg::CPL2_CYC,
    parameter int DISC_LONG_CYC = brtc_pkg::DISC_LONG_CLKS,
    parameter logic [31:0] RLIM2 = brtc_pkg::RLIM2,
    parameter logic [31:0] RLIM3 = brtc_pkg::RLIM3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic rx_pkt_chk_en,
    input wire logic rd_req,
    input wire brtc_pkg::brtc_pf_t rd_pf,
    input wire logic rd_addr_pf,
    output logic rd_len_vld,
    output logic [12:0] rd_len,
    input wire logic credit_free,
    output logic fc_update,
    input wire logic retry_term,
    input wire logic xact_done,
    output logic retry_abandon,
    input wire brtc_pkg::brtc_bctl_t bctl,
    input wire logic fwd_mode,
    input wire logic disc_start,
    input wire logic disc_done,
    output logic disc_expire,
    output logic disc_serr,
    input wire logic crs_start,
    input wire logic crs_done,
    output logic crs_timeout,
    input wire logic cpl_start,
    input wire logic cpl_done,
    output logic cpl_timeout,
    output logic dt_in_order,
    output logic irq
);
    localparam int TW = brtc_pkg::TMR_W;

    logic [31:0] tune_r;
    logic [31:0] rdsz_r;
    logic [3:0] ist_r;
    logic [3:0] imsk_r;
    logic [31:0] rcnt_r;
    logic fc_pend_r;
    logic acc;
    logic wr;
    logic full_pf;
    logic [2:0] rdsz_code;
    logic [1:0] rlim_code;
    logic [1:0] crs_code;
    logic [1:0] cpl_code;
    logic [31:0] rlim;
    logic [TW-1:0] disc_lim;
    logic [TW-1:0] crs_lim;
    logic [TW-1:0] cpl_lim;
    logic [3:0] ev;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == brtc_pkg::OFF_TUNE) || (a == brtc_pkg::OFF_RDSZ) ||
                   (a == brtc_pkg::OFF_IST) || (a == brtc_pkg::OFF_IMSK);
    endfunction : addr_hit

    function automatic logic [12:0] rdsz_bytes(input logic [2:0] c);
        case (c)
            3'h1: rdsz_bytes = 13'h0080;
            3'h2: rdsz_bytes = 13'h0100;
            3'h4: rdsz_bytes = 13'h0400;
            3'h5: rdsz_bytes = 13'h0800;
            3'h6: rdsz_bytes = 13'h1000;
            default: rdsz_bytes = brtc_pkg::RD_DEFAULT;
        endcase
    endfunction : rdsz_bytes

    assign rdsz_code = rdsz_r[brtc_pkg::B_RDSZ +: 3];
    assign rlim_code = tune_r[brtc_pkg::B_RLIM +: 2];
    assign crs_code = tune_r[brtc_pkg::B_CRS +: 2];
    assign cpl_code = tune_r[brtc_pkg::B_CPL +: 2];
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite && addr_hit(paddr);

    // APB: one cycle setup, answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_hit(paddr);
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    brtc_pkg::OFF_TUNE: prdata <= tune_r;
                    brtc_pkg::OFF_RDSZ: prdata <= rdsz_r;
                    brtc_pkg::OFF_IST: prdata <= {28'h0, ist_r};
                    brtc_pkg::OFF_IMSK: prdata <= {28'h0, imsk_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Tuning fields; expiry bit set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tune_r <= brtc_pkg::TUNE_RST;
        end else begin
            if (wr && paddr == brtc_pkg::OFF_TUNE) begin
                tune_r <= (pwdata & brtc_pkg::TUNE_WMASK) |
                          (tune_r & ~brtc_pkg::TUNE_WMASK);
                if (pwdata[brtc_pkg::B_RXP]) begin
                    tune_r[brtc_pkg::B_RXP] <= 1'b0;
                end
            end
            if (retry_term && !xact_done && rlim != 32'h0 && rcnt_r + 32'h1 == rlim) begin
                tune_r[brtc_pkg::B_RXP] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdsz_r <= brtc_pkg::RDSZ_RST;
        end else if (wr && paddr == brtc_pkg::OFF_RDSZ) begin
            rdsz_r <= pwdata & brtc_pkg::RDSZ_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pkt_chk_en <= 1'b0;
            dt_in_order <= 1'b0;
        end else begin
            rx_pkt_chk_en <= rdsz_r[brtc_pkg::B_MAL];
            dt_in_order <= tune_r[brtc_pkg::B_ORD];
        end
    end

    assign full_pf = rd_addr_pf && rd_pf.pf_a == brtc_pkg::PF_FULL &&
                     rd_pf.pf_b == brtc_pkg::PF_FULL && rd_pf.pf_c == brtc_pkg::PF_FULL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_len_vld <= 1'b0;
            rd_len <= brtc_pkg::RD_ONE_DW;
        end else begin
            rd_len_vld <= rd_req;
            if (rd_req) begin
                rd_len <= full_pf ? rdsz_bytes(rdsz_code) : brtc_pkg::RD_ONE_DW;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_update <= 1'b0;
            fc_pend_r <= 1'b0;
        end else begin
            fc_update <= credit_free && (tune_r[brtc_pkg::B_FC] || fc_pend_r);
            if (credit_free) begin
                fc_pend_r <= !tune_r[brtc_pkg::B_FC] && !fc_pend_r;
            end
        end
    end

    always_comb begin
        case (rlim_code)
            2'h1: rlim = brtc_pkg::RLIM1;
            2'h2: rlim = RLIM2;
            2'h3: rlim = RLIM3;
            default: rlim = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt_r <= 32'h0000_0000;
            retry_abandon <= 1'b0;
        end else begin
            retry_abandon <= 1'b0;
            if (xact_done) begin
                rcnt_r <= 32'h0000_0000;
            end else if (retry_term) begin
                if (rlim != 32'h0 && rcnt_r + 32'h1 == rlim) begin
                    rcnt_r <= 32'h0000_0000;
                    retry_abandon <= 1'b1;
                end else begin
                    rcnt_r <= rcnt_r + 32'h1;
                end
            end
        end
    end

    always_comb begin
        if (tune_r[brtc_pkg::B_DSHORT]) begin
            disc_lim = TW'(brtc_pkg::DISC_SHORT_CLKS);
        end else if (fwd_mode ? bctl.pri_fast : bctl.sec_fast) begin
            disc_lim = TW'(brtc_pkg::DISC_MID_CLKS);
        end else begin
            disc_lim = TW'(DISC_LONG_CYC);
        end
    end

    always_comb begin
        case (crs_code)
            2'h0: crs_lim = TW'(brtc_pkg::CRS0_CYC);
            2'h1: crs_lim = TW'(CRS1_CYC);
            2'h2: crs_lim = TW'(CRS2_CYC);
            default: crs_lim = TW'(CRS3_CYC);
        endcase
    end

    always_comb begin
        case (cpl_code)
            2'h0: cpl_lim = TW'(brtc_pkg::CPL0_CYC);
            2'h1: cpl_lim = TW'(CPL1_CYC);
            default: cpl_lim = TW'(CPL2_CYC);
        endcase
    end

    // discard timer runs while bit 19 clear
    brtc_tmr #(.W(TW)) u_disc (
        .pclk(pclk), .presetn(presetn), .start(disc_start), .stop(disc_done),
        .run_en(!tune_r[brtc_pkg::B_DDIS]), .limit(disc_lim), .busy(),
        .expire(disc_expire)
    );

    brtc_tmr #(.W(TW)) u_crs (
        .pclk(pclk), .presetn(presetn), .start(crs_start), .stop(crs_done),
        .run_en(1'b1), .limit(crs_lim), .busy(), .expire(crs_timeout)
    );

    // code 11 disables the completion timer
    brtc_tmr #(.W(TW)) u_cpl (
        .pclk(pclk), .presetn(presetn), .start(cpl_start), .stop(cpl_done),
        .run_en(cpl_code != 2'h3), .limit(cpl_lim), .busy(), .expire(cpl_timeout)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disc_serr <= 1'b0;
        end else begin
            disc_serr <= disc_expire && bctl.serr_en;
        end
    end

    // Interrupt status: set wins over write-one clear
    assign ev = {cpl_timeout, crs_timeout, disc_expire, retry_abandon};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_r <= brtc_pkg::IRQ_RST;
            imsk_r <= brtc_pkg::IRQ_RST;
            irq <= 1'b0;
        end else begin
            if (wr && paddr == brtc_pkg::OFF_IST) begin
                ist_r <= (ist_r & ~pwdata[3:0]) | ev;
            end else begin
                ist_r <= ist_r | ev;
            end
            if (wr && paddr == brtc_pkg::OFF_IMSK) begin
                imsk_r <= pwdata[3:0];
            end
            irq <= |(ist_r & imsk_r);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_mal;
        ##1 rx_pkt_chk_en == $past(rdsz_r[brtc_pkg::B_MAL]);
    endproperty
    a_mal: assert property (p_mal) else $error("check enable not bit 11");

    property p_rd_full;
        rd_req && full_pf |=> rd_len_vld && rd_len == rdsz_bytes($past(rdsz_code));
    endproperty
    a_rd_full: assert property (p_rd_full) else $error("bad full read size");

    property p_rd_part;
        rd_req && !full_pf |=> rd_len == brtc_pkg::RD_ONE_DW;
    endproperty
    a_rd_part: assert property (p_rd_part) else $error("size used without prefetch");

    property p_fc_one;
        credit_free && tune_r[brtc_pkg::B_FC] |=> fc_update;
    endproperty
    a_fc_one: assert property (p_fc_one) else $error("no update per credit");

    property p_fc_two;
        credit_free && !tune_r[brtc_pkg::B_FC] && !fc_pend_r |=> !fc_update;
    endproperty
    a_fc_two: assert property (p_fc_two) else $error("update on odd credit");

    property p_rxp;
        retry_abandon |-> tune_r[brtc_pkg::B_RXP] ##1 ist_r[0];
    endproperty
    a_rxp: assert property (p_rxp) else $error("expiry flag not set");

    property p_rlim_none;
        rlim_code == 2'h0 |=> !retry_abandon;
    endproperty
    a_rlim_none: assert property (p_rlim_none) else $error("abandon with no limit");

    property p_disc_off;
        tune_r[brtc_pkg::B_DDIS] |=> !disc_expire;
    endproperty
    a_disc_off: assert property (p_disc_off) else $error("discard timer ran disabled");

    property p_ord;
        ##1 dt_in_order == $past(tune_r[brtc_pkg::B_ORD]);
    endproperty
    a_ord: assert property (p_ord) else $error("order output mismatch");

    property p_cpl_off;
        cpl_code == 2'h3 |=> !cpl_timeout;
    endproperty
    a_cpl_off: assert property (p_cpl_off) else $error("completion timer ran disabled");

    property p_crs_min;
        crs_start |=> !crs_timeout [*8];
    endproperty
    a_crs_min: assert property (p_crs_min) else $error("config retry timeout too soon");

    property p_irq;
        ##1 irq == $past(|(ist_r & imsk_r));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level mismatch");
endmodule : brtc_ctl
`default_nettype wire

// File: brtc_pkg.sv
// Package: offsets, field positions, reset values and timing counts of the tuning block
package brtc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_TUNE = 8'h40;
    localparam logic [7:0] OFF_RDSZ = 8'h60;
    localparam logic [7:0] OFF_IST = 8'h64;
    localparam logic [7:0] OFF_IMSK = 8'h68;
    localparam int B_MAL = 11;
    localparam int B_RDSZ = 12;
    localparam int B_FC = 15;
    localparam int B_RXP = 16;
    localparam int B_RLIM = 17;
    localparam int B_DDIS = 19;
    localparam int B_DSHORT = 20;
    localparam int B_CRS = 21;
    localparam int B_ORD = 23;
    localparam int B_CPL = 24;
    localparam logic [31:0] TUNE_RST = 32'h0120_0000;
    localparam logic [31:0] TUNE_WMASK = 32'h03FE_8000;
    localparam logic [31:0] RDSZ_RST = 32'h0000_0000;
    localparam logic [31:0] RDSZ_WMASK = 32'h0000_7800;
    localparam int IRQ_W = 4;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam logic [1:0] PF_FULL = 2'h2;
    localparam logic [12:0] RD_ONE_DW = 13'h0004;
    localparam logic [12:0] RD_DEFAULT = 13'h0200;
    localparam logic [31:0] RLIM1 = 32'h0000_0100;
    localparam logic [31:0] RLIM2 = 32'h0001_0000;
    localparam logic [31:0] RLIM3 = 32'h8000_0000;
    localparam int TMR_W = 21;
    localparam int CLK_NS = 40;
    localparam int DISC_SHORT_CLKS = 64;
    localparam int DISC_MID_CLKS = 1024;
    localparam int DISC_LONG_CLKS = 32768;
    localparam int T_CRS0_NS = 25000;
    localparam int T_CRS1_NS = 500000;
    localparam int T_CRS2_NS = 5000000;
    localparam int T_CRS3_NS = 25000000;
    localparam int T_CPL0_NS = 50000;
    localparam int T_CPL1_NS = 10000000;
    localparam int T_CPL2_NS = 50000000;
    localparam int CRS0_CYC = T_CRS0_NS / CLK_NS;
    localparam int CRS1_CYC = T_CRS1_NS / CLK_NS;
    localparam int CRS2_CYC = T_CRS2_NS / CLK_NS;
    localparam int CRS3_CYC = T_CRS3_NS / CLK_NS;
    localparam int CPL0_CYC = T_CPL0_NS / CLK_NS;
    localparam int CPL1_CYC = T_CPL1_NS / CLK_NS;
    localparam int CPL2_CYC = T_CPL2_NS / CLK_NS;

    typedef struct packed {
        logic serr_en;
        logic sec_fast;
        logic pri_fast;
    } brtc_bctl_t;

    typedef struct packed {
        logic [1:0] pf_a;
        logic [1:0] pf_b;
        logic [1:0] pf_c;
    } brtc_pf_t;
endpackage : brtc_pkg

// File: brtc_tmr.sv
// One-shot timer: counts cycles from start and pulses once at the limit
`timescale 1ns/1ns
`default_nettype none
module brtc_tmr #(
    parameter int W = 21
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic stop,
    input wire logic run_en,
    input wire logic [W-1:0] limit,
    output logic busy,
    output logic expire
);
    logic [W-1:0] cnt_r;
    logic hit;

    assign hit = (cnt_r == limit - W'(1));

    // Count while armed; a stop or disable drops the run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            busy <= 1'b0;
        end else if (!run_en || stop) begin
            cnt_r <= '0;
            busy <= 1'b0;
        end else if (start) begin
            cnt_r <= '0;
            busy <= 1'b1;
        end else if (busy) begin
            cnt_r <= cnt_r + W'(1);
            busy <= !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expire <= 1'b0;
        end else begin
            expire <= run_en && !stop && !start && busy && hit;
        end
    end
endmodule : brtc_tmr
`default_nettype wire

// File: brtc_far.sv
// Far-side model: transaction engine events and bridge control levels
`timescale 1ns/1ns
`default_nettype none
module brtc_far (
    input wire logic pclk,
    output logic [9:0] ev,
    output brtc_pkg::brtc_pf_t pf,
    output logic addr_pf,
    output brtc_pkg::brtc_bctl_t bctl,
    output logic fwd
);
    initial begin
        ev = 10'h000;
        pf = 6'h2A;
        addr_pf = 1'b1;
        bctl = 3'h0;
        fwd = 1'b1;
    end
    // Event held high for n sampling edges
    task automatic pulse(input int i, input int n);
        @(posedge pclk);
        ev[i] <= 1'b1;
        repeat (n) @(posedge pclk);
        ev[i] <= 1'b0;
    endtask : pulse
    // Prefetch codes, range flag and bridge control levels
    task automatic lv(input brtc_pkg::brtc_pf_t p, input logic a,
                      input brtc_pkg::brtc_bctl_t b, input logic f);
        @(posedge pclk);
        pf <= p;
        addr_pf <= a;
        bctl <= b;
        fwd <= f;
    endtask : lv
endmodule : brtc_far
`default_nettype wire

// File: bridge_chip_control_fields_bench.sv
// Self-checking bench for the bridge tuning control block
`timescale 1ns/1ns
`default_nettype none
module bridge_chip_control_fields_bench;
    localparam int DL = 300;
    localparam logic [7:0] TU = brtc_pkg::OFF_TUNE;
    localparam logic [7:0] IM = brtc_pkg::OFF_IMSK;
    localparam logic [7:0] IS = brtc_pkg::OFF_IST;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, chk, vld;
    logic fc, ab, dex, dse, crt, cpt, ord, irq, apf, fwd;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [12:0] rlen;
    logic [9:0] ev;
    brtc_pkg::brtc_pf_t pf;
    brtc_pkg::brtc_bctl_t bctl;
    int failures = 0, n_compared = 0, n_fc = 0, n_ab = 0, n_se = 0, cyc = 0;

    brtc_far far (.pclk(pclk), .ev(ev), .pf(pf), .addr_pf(apf), .bctl(bctl), .fwd(fwd));
    brtc_ctl #(.CRS1_CYC(100), .CRS2_CYC(150), .CRS3_CYC(200), .CPL1_CYC(120),
        .CPL2_CYC(180), .DISC_LONG_CYC(DL), .RLIM2(32'h0000_012C),
        .RLIM3(32'h0000_0190)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pkt_chk_en(chk), .rd_req(ev[0]), .rd_pf(pf),
        .rd_addr_pf(apf), .rd_len_vld(vld), .rd_len(rlen), .credit_free(ev[1]),
        .fc_update(fc), .retry_term(ev[2]), .xact_done(ev[3]), .retry_abandon(ab),
        .bctl(bctl), .fwd_mode(fwd), .disc_start(ev[4]), .disc_done(ev[5]),
        .disc_expire(dex), .disc_serr(dse), .crs_start(ev[6]), .crs_done(ev[8]),
        .crs_timeout(crt), .cpl_start(ev[7]), .cpl_done(ev[9]), .cpl_timeout(cpt),
        .dt_in_order(ord), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Pulse counters and run limit
    always @(posedge pclk) begin
        cyc++;
        n_fc += (fc === 1'b1);
        n_ab += (ab === 1'b1);
        n_se += (dse === 1'b1);
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude();
        $display("Compared %0d, failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp("register", e, rdat);
    endtask : rdc
    task automatic rq(input int e);
        far.pulse(0, 1);
        @(negedge pclk);
        cmp("rd_len_vld", 32'h1, vld);
        cmp("rd_len", e, rlen);
    endtask : rq
    task automatic cr(input logic [31:0] v, input int e);
        int b;
        wr(TU, v);
        b = n_fc;
        far.pulse(1, 2);
        repeat (3) @(negedge pclk);
        cmp("fc_update", e, n_fc - b);
    endtask : cr
    task automatic rt(input logic [1:0] l, input int n, input int e, input logic clr);
        int b;
        wr(TU, 32'h0120_0000 | (32'(l) << 17));
        if (clr) begin
            far.pulse(3, 1);
        end
        b = n_ab;
        far.pulse(2, n);
        repeat (3) @(negedge pclk);
        cmp("retry_abandon", e, n_ab - b);
    endtask : rt
    task automatic tmr(input int i, input int s, input int e);
        int n;
        logic hit;
        far.pulse(i, 1);
        n = 0;
        hit = 1'b0;
        while (!hit && n < 1300) begin
            @(negedge pclk);
            n++;
            hit = ((s == 0) ? dex : (s == 1) ? crt : cpt) === 1'b1;
        end
        // Edges from the start edge to the expiry edge
        cmp("timer cycles", e, hit ? n - 1 : 0);
        repeat (2) @(negedge pclk);
    endtask : tmr

    task automatic t_reset();
        @(negedge pclk);
        cmp("rd_len", 32'h4, rlen);
        cmp("chk_en", 32'h0, chk); // off at reset
        rdc(TU, 32'h0120_0000); // field defaults
        rdc(brtc_pkg::OFF_RDSZ, 32'h0); // code zero default
        rdc(IS, 32'h0);
        rdc(IM, 32'h0);
        apb(1'b0, 8'h44, 32'h0);
        cmp("pslverr", 32'h1, rerr);
        cmp("prdata", 32'h0, rdat);
    endtask : t_reset
    task automatic t_rd();
        int sz[8] = '{512, 128, 256, 512, 1024, 2048, 4096, 512};
        for (int c = 0; c < 8; c++) begin
            wr(brtc_pkg::OFF_RDSZ, (c << 12) | 32'h0000_0800);
            rq(sz[c]); // size code
        end
        cmp("chk_en", 32'h1, chk); // on when set
        far.lv(6'h1A, 1'b1, 3'h0, 1'b1);
        rq(4); // partial prefetch
        far.lv(6'h26, 1'b1, 3'h0, 1'b1);
        rq(4); // middle field not full
        far.lv(6'h29, 1'b1, 3'h0, 1'b1);
        rq(4); // last field not full
        far.lv(6'h2A, 1'b0, 3'h0, 1'b1);
        rq(4); // outside range
        wr(brtc_pkg::OFF_RDSZ, 32'h0);
        repeat (2) @(negedge pclk);
        cmp("chk_en", 32'h0, chk); // off when clear
    endtask : t_rd
    task automatic t_retry();
        rt(2'h1, 200, 0, 1'b1);
        rt(2'h1, 200, 0, 1'b1); // count restarts
        rt(2'h1, 256, 1, 1'b1); // limit reached
        cmp("irq", 32'h0, irq);
        rdc(TU, 32'h0123_0000); // sticky set
        wr(IM, 32'h1);
        repeat (2) @(negedge pclk);
        cmp("irq", 32'h1, irq);
        rt(2'h0, 300, 0, 1'b1); // no limit
        rt(2'h2, 299, 0, 1'b1); // below limit
        rt(2'h2, 300, 1, 1'b1); // mid limit
        rt(2'h3, 400, 1, 1'b1); // top limit
        wr(TU, 32'h0121_0000);
        rdc(TU, 32'h0120_0000); // write one clears
        rdc(IS, 32'h1);
        wr(IS, 32'h1);
        rdc(IS, 32'h0);
        repeat (2) @(negedge pclk);
        cmp("irq", 32'h0, irq);
    endtask : t_retry
    task automatic t_disc();
        int b;
        wr(IM, 32'hF);
        far.lv(6'h2A, 1'b1, 3'h4, 1'b1);
        b = n_se;
        wr(TU, 32'h0130_0000);
        tmr(4, 0, 64); // short duration
        cmp("disc_serr", 32'h1, n_se - b); // report with bit 27
        wr(TU, 32'h0138_0000);
        tmr(4, 0, 0); // timer stopped
        wr(TU, 32'h0120_0000);
        tmr(4, 0, DL); // forward long
        far.lv(6'h2A, 1'b1, 3'h5, 1'b1);
        tmr(4, 0, 1024); // forward short
        far.lv(6'h2A, 1'b1, 3'h5, 1'b0);
        tmr(4, 0, DL); // reverse long
        far.lv(6'h2A, 1'b1, 3'h2, 1'b0);
        tmr(4, 0, 1024); // reverse short
        cmp("irq", 32'h1, irq);
    endtask : t_disc
    task automatic t_tmr();
        int ce[4] = '{625, 100, 150, 200};
        int pe[4] = '{1250, 120, 180, 0};
        for (int c = 0; c < 4; c++) begin
            wr(TU, 32'h0100_0000 | (c << 21));
            tmr(6, 1, ce[c]); // retry timeout code
            wr(TU, 32'h0020_0000 | (c << 24));
            tmr(7, 2, pe[c]); // completion timeout code
        end
        wr(TU, 32'h01A0_0000);
        repeat (2) @(negedge pclk);
        cmp("dt_in_order", 32'h1, ord); // strict order
        wr(TU, 32'h0120_0000);
        repeat (2) @(negedge pclk);
        cmp("dt_in_order", 32'h0, ord); // out of order
    endtask : t_tmr
    // Stop pulses cancel running timers, so no status bit is raised
    task automatic t_stop();
        wr(TU, 32'h0130_0000);
        wr(IS, 32'hF);
        far.pulse(4, 1);
        far.pulse(5, 1); // stop ends discard run
        far.pulse(6, 1);
        far.pulse(8, 1); // stop ends retry timer run
        far.pulse(7, 1);
        far.pulse(9, 1); // stop ends completion run
        repeat (200) @(negedge pclk);
        rdc(IS, 32'h0); // no expiry after stop
    endtask : t_stop

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rd();
        cr(32'h0120_0000, 1); // every two credits
        cr(32'h0120_8000, 2); // every credit
        t_retry();
        t_disc();
        t_tmr();
        t_stop();
        conclude();
    end
endmodule : bridge_chip_control_fields_bench
`default_nettype wire
